/* core/slss_pkg.sv */
// Constants and types for the single-LED short scan sequencer
package slss_pkg;

    localparam int NUM_CH       = 12;
    localparam int CH_W         = 4;
    localparam int ADC_W        = 8;
    localparam int CUR_W        = 6;
    localparam int PCODE_W      = 4;
    localparam int SEL_W        = 4;
    localparam int CNT_W        = 16;
    localparam int LIVE_HALF_CH = 6;

    localparam logic [PCODE_W-1:0] PROBE_USE_CHANNEL_CUR = 4'hF;
    localparam logic [SEL_W-1:0]   HIGHEST_OUTPUT_SELECT = 4'h5;
    localparam logic [SEL_W-1:0]   SUPPLY_SELECT         = 4'hC;
    localparam logic [CH_W-1:0]    LAST_CH               = 4'hB;
    localparam logic [CH_W-1:0]    LIVE_SECOND_FIRST     = 4'h6;
    localparam logic [CH_W-1:0]    LIVE_SECOND_END       = 4'hC;

    // Converter codes share the threshold scale, so the compare is done on codes
    localparam int SHORT_TH_OFFSET_UV = 67300;
    localparam int SHORT_TH_STEP_UV   = 80400;

    localparam int CLK_MHZ           = 125;
    localparam int CLK_PERIOD_NS     = 8;
    localparam int ERR_PULSE_US      = 50;
    localparam int ERR_PULSE_CYCLES  = ERR_PULSE_US * CLK_MHZ;
    localparam int PW_STEP_NS        = 1000;
    localparam int PW_STEP_CYCLES    = (PW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_OFF_PULSE,
        ST_OFF_WAIT,
        ST_LIVE_DELAY,
        ST_LIVE_PICK,
        ST_LIVE_WAIT,
        ST_SUP_WAIT,
        ST_HOST_WAIT
    } slss_state_t;

    typedef struct packed {
        logic             req;
        logic [SEL_W-1:0] sel;
    } slss_adc_req_t;

    typedef struct packed {
        logic [NUM_CH-1:0] chan;
        logic              out;
        logic              err;
    } slss_flags_t;

endpackage : slss_pkg

/* core/slss_err_pulse.sv */
// Low-going error pin pulse of fixed length, retriggerable
`timescale 1ns/1ps
module slss_err_pulse
    import slss_pkg::*;
#(
    parameter int unsigned COUNT = ERR_PULSE_CYCLES
)
(
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic trig_i,
    output logic      err_n_o
);

    logic [CNT_W-1:0] cnt;
    wire              busy      = (cnt != '0);
    wire  [CNT_W-1:0] next_cnt  = trig_i ? CNT_W'(COUNT) : (busy ? cnt - 1'b1 : cnt);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cnt     <= '0;
            err_n_o <= 1'b1;
        end
        else
        begin
            cnt     <= next_cnt;
            err_n_o <= (next_cnt == '0);
        end
    end

endmodule : slss_err_pulse

/* core/slss_core.sv */
// Single-LED short scan sequencer: off-state probe scan and live PWM-time scan
`timescale 1ns/1ps
module slss_core
    import slss_pkg::*;
#(
    parameter int unsigned ERR_CYCLES = ERR_PULSE_CYCLES,
    parameter int unsigned PW_STEP    = PW_STEP_CYCLES
)
(
    input  wire logic                         mclk_i,
    input  wire logic                         rst_i,
    input  wire logic                         offstate_short_scan_go_i,
    input  wire logic                         live_short_scan_enable_i,
    input  wire logic [PCODE_W-1:0]           probe_current_code_i,
    input  wire logic [PCODE_W-1:0]           probe_pulse_width_code_i,
    input  wire logic [ADC_W-1:0]             short_threshold_code_i,
    input  wire logic [ADC_W-1:0]             low_supply_threshold_i,
    input  wire logic [NUM_CH-1:0]            channel_enable_i,
    input  wire logic [NUM_CH-1:0][CUR_W-1:0] channel_current_code_i,
    input  wire logic [SEL_W-1:0]             converter_channel_select_i,
    input  wire logic                         host_conv_req_i,
    input  wire logic                         fault_flag_clear_i,
    input  wire logic                         pwm_on_i,
    input  wire logic                         adc_done_i,
    input  wire logic [ADC_W-1:0]             adc_data_i,
    output slss_adc_req_t                     adc_req_o,
    output logic [NUM_CH-1:0]                 probe_drive_o,
    output logic [CUR_W-1:0]                  probe_current_o,
    output logic                              offstate_short_scan_go_o,
    output logic                              ondemand_done_flag_o,
    output slss_flags_t                       fault_flags_o,
    output logic [ADC_W-1:0]                  converter_result_o,
    output logic                              host_conv_pending_o,
    output logic                              scan_busy_o,
    output logic                              err_n_o
);

    slss_state_t       state;
    slss_state_t       next_state;
    logic [CH_W-1:0]   ch;
    logic [CNT_W-1:0]  cnt;
    logic              half;
    logic              live_mode;
    logic              go_pend;
    logic              pwm_q;
    logic [NUM_CH-1:0] fault_pend;
    logic [ADC_W-1:0]  run_max;
    logic [ADC_W-1:0]  highest;

    wire pwm_rise   = pwm_on_i & ~pwm_q;
    wire start_req  = offstate_short_scan_go_i | go_pend;
    wire in_idle    = (state == ST_IDLE);
    wire start_off  = in_idle & start_req;
    wire start_live = in_idle & ~start_req & live_short_scan_enable_i & pwm_rise;
    wire start_host = in_idle & ~start_req & ~start_live & host_conv_pending_o;

    wire [CNT_W-1:0] pw_cycles = CNT_W'((32'(probe_pulse_width_code_i) + 32'd1) * PW_STEP);
    wire             cnt_done  = (cnt == '0);
    wire [CH_W-1:0]  live_end  = half ? LIVE_SECOND_END : CH_W'(LIVE_HALF_CH);
    wire [CH_W-1:0]  live_first = half ? LIVE_SECOND_FIRST : '0;
    wire             ch_on     = channel_enable_i[ch];
    wire             below_th  = adc_data_i < short_threshold_code_i;
    wire             supply_ok = adc_data_i >= low_supply_threshold_i;
    wire             sup_done  = (state == ST_SUP_WAIT) & adc_done_i;
    wire             commit    = sup_done & supply_ok & (|fault_pend);
    wire             conv_done = adc_done_i & ((state == ST_OFF_WAIT) | (state == ST_LIVE_WAIT));
    wire             show_max  = live_short_scan_enable_i & (converter_channel_select_i == HIGHEST_OUTPUT_SELECT);

    // Channel that the off scan drives in the coming cycle
    function automatic logic [CH_W-1:0] ch_next_off(
        input logic            go,
        input slss_state_t     st,
        input logic [CH_W-1:0] c
    );
        if (go)
            return '0;
        else if (st == ST_OFF_WAIT)
            return c + 1'b1;
        else
            return c;
    endfunction : ch_next_off

    wire [CH_W-1:0] off_ch = ch_next_off(start_off, state, ch);

    // Code Fh borrows the channel's own current so the probe matches lit operation.
    // Indexed by the coming channel, else a new pulse opens with its neighbour's current.
    wire [CUR_W-1:0] sel_current = (probe_current_code_i == PROBE_USE_CHANNEL_CUR) ?
                                   channel_current_code_i[off_ch] : CUR_W'(probe_current_code_i);

    logic          next_fire;
    logic [SEL_W-1:0] next_sel;

    always_comb
    begin
        next_state = state;
        next_fire  = 1'b0;
        next_sel   = SEL_W'(ch);
        unique case (state)
            ST_IDLE:
            begin
                if (start_off)
                    next_state = ST_OFF_PULSE;
                else if (start_live)
                    next_state = ST_LIVE_DELAY;
                else if (start_host)
                begin
                    next_state = ST_HOST_WAIT;
                    next_fire  = 1'b1;
                    next_sel   = converter_channel_select_i;
                end
            end
            ST_OFF_PULSE:
            begin
                if (cnt_done)
                begin
                    next_state = ST_OFF_WAIT;
                    next_fire  = 1'b1;
                end
            end
            ST_OFF_WAIT:
            begin
                if (adc_done_i && ch == LAST_CH)
                begin
                    next_state = ST_SUP_WAIT;
                    next_fire  = 1'b1;
                    next_sel   = SUPPLY_SELECT;
                end
                else if (adc_done_i)
                    next_state = ST_OFF_PULSE;
            end
            ST_LIVE_DELAY:
            begin
                if (cnt_done)
                    next_state = ST_LIVE_PICK;
            end
            ST_LIVE_PICK:
            begin
                if (ch == live_end)
                begin
                    next_state = ST_SUP_WAIT;
                    next_fire  = 1'b1;
                    next_sel   = SUPPLY_SELECT;
                end
                else if (ch_on)
                begin
                    next_state = ST_LIVE_WAIT;
                    next_fire  = 1'b1;
                end
            end
            ST_LIVE_WAIT:
            begin
                if (adc_done_i)
                    next_state = ST_LIVE_PICK;
            end
            ST_SUP_WAIT:
            begin
                if (adc_done_i)
                    next_state = ST_IDLE;
            end
            ST_HOST_WAIT:
            begin
                if (adc_done_i)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Channel index and timing counter
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            ch    <= '0;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            if (start_off)
                ch <= '0;
            else if (start_live)
                ch <= live_first;
            else if (conv_done || (state == ST_LIVE_PICK && !ch_on && ch != live_end))
                ch <= ch + 1'b1;
            if (start_off || start_live || (state == ST_OFF_WAIT && adc_done_i))
                cnt <= pw_cycles - 1'b1;
            else if (!cnt_done)
                cnt <= cnt - 1'b1;
        end
    end

    // Probe drive, current and converter request
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            probe_drive_o   <= '0;
            probe_current_o <= '0;
            adc_req_o       <= '0;
        end
        else
        begin
            probe_drive_o   <= (next_state == ST_OFF_PULSE) ? NUM_CH'(1) << off_ch : '0;
            probe_current_o <= (next_state == ST_OFF_PULSE) ? sel_current : '0;
            adc_req_o.req   <= next_fire;
            adc_req_o.sel   <= next_sel;
        end
    end

    // Scan bookkeeping: mode, half, pending faults and the running maximum
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            live_mode  <= 1'b0;
            half       <= 1'b0;
            fault_pend <= '0;
            run_max    <= '0;
            highest    <= '0;
            pwm_q      <= 1'b0;
        end
        else
        begin
            pwm_q <= pwm_on_i;
            if (start_off || start_live)
            begin
                live_mode  <= start_live;
                fault_pend <= '0;
            end
            else if (conv_done && below_th)
                fault_pend[ch] <= 1'b1;
            if (start_live && !half)
                run_max <= '0;
            else if (state == ST_LIVE_WAIT && adc_done_i && adc_data_i > run_max)
                run_max <= adc_data_i;
            if (sup_done && live_mode)
            begin
                half <= ~half;
                if (half)
                    highest <= run_max;
            end
        end
    end

    // Flags: a fault arriving with a clear still sets
    wire [NUM_CH-1:0] set_chan = commit ? fault_pend : '0;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            fault_flags_o            <= '0;
            ondemand_done_flag_o     <= 1'b0;
            offstate_short_scan_go_o <= 1'b0;
            go_pend                  <= 1'b0;
            host_conv_pending_o      <= 1'b0;
            converter_result_o       <= '0;
            scan_busy_o              <= 1'b0;
        end
        else
        begin
            fault_flags_o.chan <= (fault_flag_clear_i ? '0 : fault_flags_o.chan) | set_chan;
            fault_flags_o.out  <= (fault_flag_clear_i ? 1'b0 : fault_flags_o.out) | commit;
            fault_flags_o.err  <= (fault_flag_clear_i ? 1'b0 : fault_flags_o.err) | commit;
            offstate_short_scan_go_o <= offstate_short_scan_go_i;
            go_pend  <= start_req & ~start_off;
            if (start_off)
                ondemand_done_flag_o <= 1'b0;
            else if (sup_done && !live_mode)
                ondemand_done_flag_o <= 1'b1;
            host_conv_pending_o <= (host_conv_pending_o & ~start_host) | host_conv_req_i;
            if (state == ST_HOST_WAIT && adc_done_i)
                converter_result_o <= show_max ? highest : adc_data_i;
            else if (show_max && sup_done && live_mode && half)
                converter_result_o <= run_max;
            scan_busy_o <= (next_state != ST_IDLE) & (next_state != ST_HOST_WAIT);
        end
    end

    slss_err_pulse #(
        .COUNT   (ERR_CYCLES)
    ) u_err (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .trig_i  (commit),
        .err_n_o (err_n_o)
    );

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    logic [CNT_W-1:0] low_len;
    always_ff @(posedge mclk_i)
    begin
        if (rst_i || err_n_o)
            low_len <= '0;
        else
            low_len <= low_len + 1'b1;
    end

    sequence s_off_launch;
        in_idle && offstate_short_scan_go_i;
    endsequence

    sequence s_pulse_end;
        $fell(|probe_drive_o) ##0 adc_req_o.req;
    endsequence

    a_go_self_clear: assert property (offstate_short_scan_go_o |=> !offstate_short_scan_go_o || $past(offstate_short_scan_go_i, 1))
        else $error("go bit stayed set");
    a_done_clears: assert property (s_off_launch |=> !ondemand_done_flag_o ##1 (|probe_drive_o))
        else $error("done flag not cleared or probe not driven");
    a_probe_one_hot: assert property ($onehot0(probe_drive_o))
        else $error("more than one output probed");
    a_pulse_then_conv: assert property ($fell(|probe_drive_o) |-> s_pulse_end)
        else $error("no conversion at pulse end");
    a_low_supply_quiet: assert property (sup_done && !supply_ok |=> fault_flags_o.chan == ($past(fault_flags_o.chan) & ~{NUM_CH{$past(fault_flag_clear_i)}}))
        else $error("fault flagged at low supply");
    a_err_width: assert property ($rose(err_n_o) |-> low_len == CNT_W'(ERR_CYCLES))
        else $error("error pulse width wrong");
    a_fault_sets_all: assert property (commit |=> fault_flags_o.out && fault_flags_o.err && !err_n_o && |fault_flags_o.chan)
        else $error("fault flags incomplete");
    a_flags_latched: assert property ((|($past(fault_flags_o.chan) & ~fault_flags_o.chan)) |-> $past(fault_flag_clear_i))
        else $error("flag dropped without clear");
    a_probe_current: assert property ((next_state == ST_OFF_PULSE) && probe_current_code_i == PROBE_USE_CHANNEL_CUR
        && state == ST_OFF_PULSE |=> probe_current_o == $past(channel_current_code_i[ch]))
        else $error("probe current source wrong");
    a_live_delay: assert property (start_live |=> !adc_req_o.req [*2])
        else $error("live conversion before delay");
    a_skip_disabled: assert property (state == ST_LIVE_PICK && !ch_on && ch != live_end |=> !adc_req_o.req)
        else $error("disabled channel converted");
    a_host_waits: assert property ($rose(state == ST_HOST_WAIT) |-> $past(in_idle) && !$past(live_mode && scan_busy_o))
        else $error("host conversion during scan");

endmodule : slss_core

/* dv/slss_adc_model.sv */
// Behavioural converter that serves the sequencer's conversion requests
`timescale 1ns/1ps
module slss_adc_model
    import slss_pkg::*;
(
    input  wire logic                   mclk_i,
    input  wire logic                   rst_i,
    input  wire slss_adc_req_t          adc_req_i,
    input  wire logic [7:0]             lat_i,
    input  wire logic [15:0][ADC_W-1:0] vals_i,
    output logic                        adc_done_o,
    output logic [ADC_W-1:0]            adc_data_o
);
    logic             busy;
    logic [7:0]       cnt;
    logic [SEL_W-1:0] sel;

    // One conversion at a time; data toggles outside the done cycle so stale values never look valid
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            busy       <= 1'b0;
            cnt        <= 8'h00;
            sel        <= 4'h0;
            adc_done_o <= 1'b0;
            adc_data_o <= 8'h00;
        end
        else
        begin
            adc_done_o <= 1'b0;
            adc_data_o <= ~adc_data_o;
            if (adc_req_i.req && !busy)
            begin
                busy <= 1'b1;
                sel  <= adc_req_i.sel;
                cnt  <= lat_i;
            end
            else if (busy && cnt == 8'h00)
            begin
                busy       <= 1'b0;
                adc_done_o <= 1'b1;
                adc_data_o <= vals_i[sel];
            end
            else if (busy)
                cnt <= cnt - 8'h01;
        end
    end
endmodule : slss_adc_model

/* dv/single_led_short_scan_tb.sv */
// Self-checking testbench for the single-LED short scan sequencer
`timescale 1ns/1ps
module single_led_short_scan_tb
    import slss_pkg::*;
;
    localparam int ERRC = 20;
    localparam int PWS  = 2;
    logic                         mclk_i, rst_i, go, live_en, host_req, clr, pwm;
    logic [PCODE_W-1:0]           pcode, wcode;
    logic [ADC_W-1:0]             th, lowth, result;
    logic [NUM_CH-1:0]            en, drive;
    logic [NUM_CH-1:0][CUR_W-1:0] cur;
    logic [SEL_W-1:0]             csel;
    logic [7:0]                   lat;
    logic [15:0][ADC_W-1:0]       vals;
    slss_adc_req_t                areq;
    slss_flags_t                  flags;
    logic                         adone, go_o, done_o, pend_o, busy_o, err_n;
    logic [ADC_W-1:0]             adata;
    logic [CUR_W-1:0]             pcur;
    logic [SEL_W-1:0]             sels[$];
    int                           err_count = 0, n_compared = 0, pw_cnt = 0, low_cnt = 0, n_pulses = 0, exp_ch = 0;

    slss_core #(.ERR_CYCLES(ERRC), .PW_STEP(PWS)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .offstate_short_scan_go_i(go), .live_short_scan_enable_i(live_en),
        .probe_current_code_i(pcode), .probe_pulse_width_code_i(wcode), .short_threshold_code_i(th),
        .low_supply_threshold_i(lowth), .channel_enable_i(en), .channel_current_code_i(cur),
        .converter_channel_select_i(csel), .host_conv_req_i(host_req), .fault_flag_clear_i(clr),
        .pwm_on_i(pwm), .adc_done_i(adone), .adc_data_i(adata), .adc_req_o(areq), .probe_drive_o(drive),
        .probe_current_o(pcur), .offstate_short_scan_go_o(go_o), .ondemand_done_flag_o(done_o),
        .fault_flags_o(flags), .converter_result_o(result), .host_conv_pending_o(pend_o),
        .scan_busy_o(busy_o), .err_n_o(err_n));

    slss_adc_model i_adc (.mclk_i(mclk_i), .rst_i(rst_i), .adc_req_i(areq), .lat_i(lat), .vals_i(vals),
        .adc_done_o(adone), .adc_data_o(adata));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic tick(input int n = 1);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic wait_idle();
        int i;
        i = 0;
        while (busy_o !== 1'b0 && i < 3000)
        begin
            tick();
            i++;
        end
        check("scan finished", 1, busy_o === 1'b0);
    endtask : wait_idle

    // Records conversions, probe pulses and error pulses as the design presents them
    always @(posedge mclk_i)
    begin
        if (!rst_i)
        begin
            if (areq.req === 1'b1)
                sels.push_back(areq.sel);
            if (drive !== 12'h000)
            begin
                if (pw_cnt == 0)
                begin
                    check("probe drive", 12'h001 << exp_ch, drive);
                    exp_ch++;
                end
                check("probe current", (pcode == PROBE_USE_CHANNEL_CUR) ? 32'(cur[exp_ch-1]) : 32'(pcode), pcur);
                pw_cnt++;
            end
            else if (pw_cnt != 0)
            begin
                check("pulse width", (wcode + 1) * PWS, pw_cnt);
                pw_cnt = 0;
            end
            if (err_n === 1'b0)
                low_cnt++;
            else if (low_cnt != 0)
            begin
                check("error pulse", ERRC, low_cnt);
                n_pulses++;
                low_cnt = 0;
            end
        end
    end

    task automatic off_scan(input logic [NUM_CH-1:0] exp_chan, input int exp_p, input logic host);
        int p0;
        p0 = n_pulses;
        sels.delete();
        exp_ch = 0;
        tick();
        go <= 1'b1;
        tick();
        go <= 1'b0;
        host_req <= host;
        #1;
        check("go readback", 1, go_o);
        check("done cleared", 0, done_o);
        tick();
        host_req <= 1'b0;
        #1;
        check("go self clear", 0, go_o);
        tick(3);
        if (host)
            check("host pending", 1, pend_o);
        wait_idle();
        tick(ERRC + 30);
        check("done set", 1, done_o);
        check("channels probed", 12, exp_ch);
        check("conv count", 13 + host, sels.size());
        for (int c = 0; c < 12; c++)
            check("conv order", c, sels[c]);
        check("supply conv", 4'hC, sels[12]);
        if (host)
            check("host result", vals[csel], result);
        check("chan flags", exp_chan, flags.chan);
        check("out flag", |exp_chan, flags.out);
        check("err flag", |exp_chan, flags.err);
        check("pulse count", p0 + exp_p, n_pulses);
    endtask : off_scan

    task automatic live_half(input int first);
        int n;
        int k;
        sels.delete();
        tick();
        pwm <= 1'b1;
        n = 0;
        while (areq.req !== 1'b1 && n < 200)
        begin
            tick();
            n++;
        end
        check("settle delay", 1, n >= (wcode + 1) * PWS && n <= (wcode + 1) * PWS + 4);
        tick(80);
        check("scan inside on time", 0, busy_o);
        pwm <= 1'b0;
        tick(ERRC + 10);
        k = 0;
        for (int c = first; c < first + 6; c++)
            if (en[c])
            begin
                check("live order", c, sels[k]);
                k++;
            end
        check("live supply", 4'hC, sels[k]);
        check("live skips", k + 1, sels.size());
    endtask : live_half

    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    initial
    begin
        #320000;
        err_count++;
        $display("watchdog expired");
        wrap_up();
    end

    initial
    begin
        rst_i = 1'b1;
        {go, live_en, host_req, clr, pwm} = 5'h00;
        pcode = 4'hF;
        wcode = 4'h1;
        th = 8'h40;
        lowth = 8'h50;
        en = 12'h000;
        csel = 4'hD;
        lat = 8'h03;
        for (int c = 0; c < 16; c++)
            vals[c] = 8'h60 + 8'(c);
        for (int c = 0; c < NUM_CH; c++)
            cur[c] = 6'(3 * c + 1);
        vals[3] = 8'h40;
        vals[12] = 8'h80;
        tick(10);
        rst_i <= 1'b0;
        tick();
        #1;
        check("reset flags", 0, flags);
        check("reset done", 0, done_o);
        check("reset err pin", 1, err_n);
        off_scan(12'h000, 0, 1'b1);
        vals[11] <= 8'h3F;
        wcode <= 4'h2;
        lat <= 8'h0C;
        off_scan(12'h800, 1, 1'b0);
        tick(40);
        check("flags latched", 12'h800, flags.chan);
        clr <= 1'b1;
        tick();
        clr <= 1'b0;
        tick(2);
        check("flags cleared", 0, flags);
        vals[12] <= 8'h4F;
        pcode <= 4'h7;
        off_scan(12'h000, 0, 1'b0);
        vals[12] <= 8'h80;
        vals[11] <= 8'h70;
        wcode <= 4'h1;
        lat <= 8'h03;
        en <= 12'hEFB;
        vals[2] <= 8'hF0;
        vals[10] <= 8'hA0;
        vals[7] <= 8'h10;
        csel <= HIGHEST_OUTPUT_SELECT;
        live_en <= 1'b1;
        live_half(0);
        check("first half flags", 0, flags);
        live_half(6);
        check("live fault", 12'h080, flags.chan);
        check("highest output", 8'hA0, result);
        clr <= 1'b1;
        tick();
        clr <= 1'b0;
        vals[1] <= 8'h10;
        vals[12] <= 8'h4F;
        live_half(0);
        check("low supply live", 0, flags);
        wrap_up();
    end
endmodule : single_led_short_scan_tb
